// ---- logic/sra_pkg.sv ----
// Constants, state codes and the command carrier for the serial register access host.
// Assumes a 100 MHz system clock; all bus timing is derived from it here.
package sra_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  // Each serial bit is cut into four equal quarters; these are the quarter counts.
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SPI_SCLK_PERIOD_NS = 1000;
  localparam int I2C_SCL_PERIOD_NS  = 10000;
  localparam int SPI_QTR_CYC = (SPI_SCLK_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int I2C_QTR_CYC = (I2C_SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int TMR_W       = 9;
  localparam logic [TMR_W-1:0] SPI_QTR_LOAD = TMR_W'(SPI_QTR_CYC - 1);
  localparam logic [TMR_W-1:0] I2C_QTR_LOAD = TMR_W'(I2C_QTR_CYC - 1);

  // ---------------------------------------------------------------------------
  // Protocol fields
  // ---------------------------------------------------------------------------
  // Upper address bits are fixed; the low bit follows the address select strap.
  localparam logic [6:0] I2C_DEV_ADDR_BASE = 7'h20;
  localparam logic       DIR_WRITE         = 1'b0;
  localparam logic       DIR_READ          = 1'b1;
  localparam logic [3:0] SPI_LAST_BIT      = 4'h7;
  localparam logic [3:0] ACK_BIT           = 4'h8;
  localparam logic [7:0] RELEASE_BYTE      = 8'hff;
  localparam logic [3:0] SPI_BITS_LOG2     = 4'h3;

  // Byte phases within one transfer.
  localparam logic [1:0] PH_HEAD    = 2'h0;
  localparam logic [1:0] PH_INDEX   = 2'h1;
  localparam logic [1:0] PH_ADDR_RD = 2'h2;
  localparam logic [1:0] PH_DATA    = 2'h3;

  // Quarter codes of a bit period.
  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_START   = 6'h02,
    ST_LOAD    = 6'h04,
    ST_SHIFT   = 6'h08,
    ST_RESTART = 6'h10,
    ST_STOP    = 6'h20
  } sra_state_e;

  // One request: bus choice, direction, register index and burst length minus one.
  typedef struct packed {
    logic       useI2c;
    logic       isRead;
    logic [6:0] regIndex;
    logic [7:0] extraBytes;
  } sra_cmd_s;

endpackage

// ---- logic/sra_host.sv ----
// Host-side master for a sensor register port over a two-wire bus or a mode-00 serial link.
// Assumes pins are resolved outside (open-drain and three-state) and that the caller
// knows which wire mode the device was set to.
//
// Contract
// - Start: data falls while clock high.
// - First byte: seven address bits, direction.
// - Ninth clock pulse is acknowledge slot.
// - Sender releases data; receiver holds low.
// - Stop: data rises while clock high.
// - Master ends read with nack, stop.
// - Single read uses repeated start, direction one.
// - Single write: address, index, data, stop.
// - Mode 00: idle low, sample rising.
// - Select low for whole transfer, then high.
// - Sixteen clocks single, eight per extra.
// - Write data follows header, MSB first.
`timescale 1ns/1ns

module sra_host (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire sra_pkg::sra_cmd_s cmd,
  input  wire logic              addressLsbPin,
  input  wire logic              threeWireSelect,
  input  wire logic              wrValid,
  output logic                   wrReady,
  input  wire logic [7:0]        wrData,
  output logic                   rdValid,
  output logic [7:0]             rdData,
  output logic                   done,
  output logic                   nackSeen,
  output logic                   busy,
  output logic                   sclOut,
  output logic                   sclOe,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  output logic                   spiClk,
  output logic                   spiCsN,
  input  wire logic              spiDataIn,
  output logic                   spiDataOut,
  output logic                   spiDataOe,
  input  wire logic              spiMiso
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  sra_pkg::sra_state_e          stateReg, stateNext;
  logic [1:0]                   qReg, qNext, phaseReg, phaseNext;
  logic [sra_pkg::TMR_W-1:0]    tmrReg, tmrNext;
  logic [3:0]                   bitReg, bitNext;
  logic [7:0]                   shReg, shNext, rxReg, rxNext, rdDataNext;
  logic [7:0]                   remainReg, remainNext, lenReg, lenNext;
  logic [6:0]                   idxReg, idxNext, devReg, devNext;
  logic                         ackBitReg, ackBitNext, i2cReg, i2cNext, readReg, readNext;
  logic                         wire3Reg, wire3Next, nackNext, rdValidNext, doneNext;
  logic                         sdaReg, sclOeReg, sdaOeReg, spiClkReg, spiCsNReg, dOeReg;
  logic [2:0]                   sync1Reg, sync2Reg;

  // ---------------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------------
  wire tick    = (tmrReg == '0);
  wire accept  = (stateReg == sra_pkg::ST_IDLE) && cmdValid;
  wire modeSel = accept ? cmd.useI2c : i2cReg;
  wire rxByte  = readReg && (phaseReg == sra_pkg::PH_DATA);
  wire ackSlot = rxByte ? (remainReg == 8'h00) : 1'b1;
  wire bitVal  = (bitReg == sra_pkg::ACK_BIT) ? ackSlot : shReg[7];
  wire [3:0] lastBit = i2cReg ? sra_pkg::ACK_BIT : sra_pkg::SPI_LAST_BIT;
  wire [sra_pkg::TMR_W-1:0] qtrLoad = i2cReg ? sra_pkg::I2C_QTR_LOAD : sra_pkg::SPI_QTR_LOAD;
  wire [6:0] devSel = {sra_pkg::I2C_DEV_ADDR_BASE[6:1], addressLsbPin};
  // The clock line is never sampled: the device keeps pace and never stretches.
  wire inBit = i2cReg ? sync2Reg[0] : (wire3Reg ? sync2Reg[2] : sync2Reg[1]);

  // Line levels for the next cycle; the two-wire clock is high in the upper quarters.
  wire isIdle  = (stateReg == sra_pkg::ST_IDLE);
  wire isStart = (stateReg == sra_pkg::ST_START);
  wire isShift = (stateReg == sra_pkg::ST_SHIFT);
  wire isRst   = (stateReg == sra_pkg::ST_RESTART);
  wire isStop  = (stateReg == sra_pkg::ST_STOP);
  wire clkLvl  = isIdle ? modeSel :
                 isStart ? i2cReg :
                 (stateReg == sra_pkg::ST_LOAD) ? 1'b0 :
                 (isStop && !i2cReg) ? 1'b0 : qReg[1];
  wire sdaLvl  = isIdle ? 1'b1 :
                 isStart ? (i2cReg ? (qReg == sra_pkg::Q0) : shReg[7]) :
                 isShift ? ((i2cReg && qReg == sra_pkg::Q0) ? sdaReg : bitVal) :
                 isRst ? ((qReg == sra_pkg::Q0) ? sdaReg : (qReg != sra_pkg::Q3)) :
                 (isStop && i2cReg) ? ((qReg == sra_pkg::Q0) ? sdaReg : (qReg == sra_pkg::Q3)) :
                 sdaReg;
  wire csLvl   = i2cReg || isIdle || (isStop && qReg != sra_pkg::Q0);
  // In three-wire reads the shared line is released once the header byte is out.
  wire oeLvl   = !modeSel && !csLvl && !(wire3Reg && rxByte);

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // Walks start, bytes with acknowledge slots, repeated start and stop.
  always_comb begin
    stateNext   = stateReg;
    qNext       = qReg;
    tmrNext     = isIdle ? tmrReg : (tick ? qtrLoad : tmrReg - 9'h001);
    bitNext     = bitReg;
    phaseNext   = phaseReg;
    shNext      = shReg;
    rxNext      = rxReg;
    ackBitNext  = ackBitReg;
    remainNext  = remainReg;
    lenNext     = lenReg;
    i2cNext     = i2cReg;
    readNext    = readReg;
    idxNext     = idxReg;
    wire3Next   = wire3Reg;
    devNext     = devReg;
    rdDataNext  = rdData;
    rdValidNext = 1'b0;
    doneNext    = 1'b0;
    nackNext    = nackSeen;
    unique case (stateReg)
      sra_pkg::ST_IDLE: begin
        if (accept) begin
          i2cNext    = cmd.useI2c;
          readNext   = cmd.isRead;
          idxNext    = cmd.regIndex;
          remainNext = cmd.extraBytes;
          lenNext    = cmd.extraBytes;
          wire3Next  = threeWireSelect;
          devNext    = devSel;
          nackNext   = 1'b0;
          phaseNext  = sra_pkg::PH_HEAD;
          bitNext    = 4'h0;
          qNext      = sra_pkg::Q0;
          tmrNext    = cmd.useI2c ? sra_pkg::I2C_QTR_LOAD : sra_pkg::SPI_QTR_LOAD;
          stateNext  = sra_pkg::ST_START;
          // Two-wire opens with address and write; the link with direction and index.
          shNext = cmd.useI2c ? {devSel, sra_pkg::DIR_WRITE} : {cmd.isRead, cmd.regIndex};
        end
      end
      sra_pkg::ST_START: begin
        if (tick) begin
          qNext = qReg + 2'h1;
          if (qReg == (i2cReg ? sra_pkg::Q3 : sra_pkg::Q1)) begin
            qNext     = sra_pkg::Q0;
            stateNext = sra_pkg::ST_SHIFT;
          end
        end
      end
      sra_pkg::ST_SHIFT: begin
        if (tick) begin
          qNext = qReg + 2'h1;
          if (qReg == sra_pkg::Q2) begin
            if (bitReg == sra_pkg::ACK_BIT) begin
              ackBitNext = inBit;
            end else begin
              rxNext = {rxReg[6:0], inBit};
            end
          end
          if (qReg == sra_pkg::Q3 && bitReg != lastBit) begin
            bitNext = bitReg + 4'h1;
            shNext  = {shReg[6:0], 1'b1};
          end else if (qReg == sra_pkg::Q3) begin
            bitNext = 4'h0;
            if (rxByte) begin
              rdDataNext  = rxReg;
              rdValidNext = 1'b1;
            end
            if (i2cReg && !rxByte && ackBitReg) begin
              nackNext  = 1'b1;
              stateNext = sra_pkg::ST_STOP;
            end else if (phaseReg == sra_pkg::PH_DATA) begin
              if (remainReg == 8'h00) begin
                stateNext = sra_pkg::ST_STOP;
              end else begin
                remainNext = remainReg - 8'h01;
                stateNext  = sra_pkg::ST_LOAD;
              end
            end else if (phaseReg == sra_pkg::PH_INDEX && readReg) begin
              stateNext = sra_pkg::ST_RESTART;
            end else if (phaseReg == sra_pkg::PH_HEAD && i2cReg) begin
              phaseNext = sra_pkg::PH_INDEX;
              shNext    = {1'b0, idxReg};
            end else begin
              phaseNext = sra_pkg::PH_DATA;
              stateNext = sra_pkg::ST_LOAD;
            end
          end
        end
      end
      // Each write data byte is fetched here and a read byte loads the release pattern; the device steps its own index per byte.
      sra_pkg::ST_LOAD: begin
        if (readReg || wrValid) begin
          shNext    = readReg ? sra_pkg::RELEASE_BYTE : wrData;
          tmrNext   = qtrLoad;
          stateNext = sra_pkg::ST_SHIFT;
        end
      end
      sra_pkg::ST_RESTART: begin
        if (tick) begin
          qNext = qReg + 2'h1;
          if (qReg == sra_pkg::Q3) begin
            phaseNext = sra_pkg::PH_ADDR_RD;
            shNext    = {devReg, sra_pkg::DIR_READ};
            stateNext = sra_pkg::ST_SHIFT;
          end
        end
      end
      sra_pkg::ST_STOP: begin
        if (tick) begin
          qNext = qReg + 2'h1;
          if (qReg == (i2cReg ? sra_pkg::Q3 : sra_pkg::Q1)) begin
            qNext     = sra_pkg::Q0;
            doneNext  = 1'b1;
            stateNext = sra_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        stateNext = sra_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateReg <= sra_pkg::ST_IDLE;
      qReg     <= 2'h0;
      tmrReg   <= '0;
      bitReg   <= 4'h0;
      phaseReg <= 2'h0;
      shReg    <= 8'hff;
      rxReg    <= 8'h00;
      remainReg <= 8'h00;
      lenReg   <= 8'h00;
    end else if (ce) begin
      stateReg <= stateNext;
      qReg     <= qNext;
      tmrReg   <= tmrNext;
      bitReg   <= bitNext;
      phaseReg <= phaseNext;
      shReg    <= shNext;
      rxReg    <= rxNext;
      remainReg <= remainNext;
      lenReg   <= lenNext;
    end
  end

  // Request fields, result flags and read data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ackBitReg, i2cReg, readReg, wire3Reg} <= 4'h2;
      idxReg   <= 7'h00;
      devReg   <= 7'h00;
      rdData   <= 8'h00;
      rdValid  <= 1'b0;
      done     <= 1'b0;
      nackSeen <= 1'b0;
    end else if (ce) begin
      {ackBitReg, i2cReg, readReg, wire3Reg} <= {ackBitNext, i2cNext, readNext, wire3Next};
      idxReg   <= idxNext;
      devReg   <= devNext;
      rdData   <= rdDataNext;
      rdValid  <= rdValidNext;
      done     <= doneNext;
      nackSeen <= nackNext;
    end
  end

  // Pin drivers and two-flop synchronisers for the returning data lines.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {sdaReg, sclOeReg, sdaOeReg} <= 3'h4;
      {spiClkReg, spiCsNReg, dOeReg} <= 3'h2;
      sync1Reg <= 3'h7;
      sync2Reg <= 3'h7;
    end else if (ce) begin
      {sdaReg, sclOeReg, sdaOeReg} <= {sdaLvl, modeSel && !clkLvl, modeSel && !sdaLvl};
      {spiClkReg, spiCsNReg, dOeReg} <= {!modeSel && clkLvl, csLvl, oeLvl};
      sync1Reg <= {spiDataIn, spiMiso, sdaIn};
      sync2Reg <= sync1Reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign cmdReady   = isIdle && ce;
  assign wrReady    = (stateReg == sra_pkg::ST_LOAD) && !readReg && ce;
  assign busy       = !isIdle;
  assign sclOut     = 1'b0;
  assign sclOe      = sclOeReg;
  assign sdaOut     = 1'b0;
  assign sdaOe      = sdaOeReg;
  assign spiClk     = spiClkReg;
  assign spiCsN     = spiCsNReg;
  assign spiDataOut = sdaReg;
  assign spiDataOe  = dOeReg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Rising link clock edges counted inside one select-low frame.
  logic [11:0] edgeCntReg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeCntReg <= 12'h000;
    end else if (ce) begin
      if (spiCsNReg) begin
        edgeCntReg <= 12'h000;
      end else if (!spiClkReg && !modeSel && clkLvl) begin
        edgeCntReg <= edgeCntReg + 12'h001;
      end
    end
  end

  startCond_a: assert property (@(posedge clk) disable iff (rst)
    (i2cReg && $fell(sdaReg) && !sclOeReg && !$past(sclOeReg))
      |-> ($past(stateReg) == sra_pkg::ST_START || $past(stateReg) == sra_pkg::ST_RESTART))
    else $error("data fell under high clock outside a start");

  stopCond_a: assert property (@(posedge clk) disable iff (rst)
    (i2cReg && $rose(sdaReg) && !sclOeReg && !$past(sclOeReg))
      |-> $past(stateReg) == sra_pkg::ST_STOP)
    else $error("data rose under high clock outside a stop");

  ackRelease_a: assert property (@(posedge clk) disable iff (rst)
    (i2cReg && isShift && bitReg == sra_pkg::ACK_BIT && qReg[1] && !rxByte) |-> !sdaOeReg)
    else $error("host drove data during the device acknowledge");

  readNack_a: assert property (@(posedge clk) disable iff (rst)
    (i2cReg && isShift && bitReg == sra_pkg::ACK_BIT && qReg[1] && rxByte)
      |-> (sdaOeReg == (remainReg != 8'h00)))
    else $error("host acknowledge does not match the remaining count");

  addrByte_a: assert property (@(posedge clk) disable iff (rst)
    (i2cReg && isShift && phaseReg == sra_pkg::PH_HEAD && bitReg == 4'h0)
      |-> shReg == {devReg, sra_pkg::DIR_WRITE})
    else $error("first two-wire byte is not the write address");

  spiIdle_a: assert property (@(posedge clk) disable iff (rst)
    spiCsNReg |-> !spiClkReg ##1 !spiClkReg)
    else $error("link clock not low while deselected");

  dataStable_a: assert property (@(posedge clk) disable iff (rst)
    (!i2cReg && spiClkReg && $past(spiClkReg)) |-> $stable(sdaReg))
    else $error("link data changed while the clock was high");

  cmdDir_a: assert property (@(posedge clk) disable iff (rst)
    (!i2cReg && phaseReg == sra_pkg::PH_HEAD && bitReg == 4'h0 && $rose(spiClkReg))
      |-> sdaReg == readReg)
    else $error("first link bit is not the direction");

  frameLen_a: assert property (@(posedge clk) disable iff (rst)
    (!i2cReg && $rose(spiCsNReg))
      |-> edgeCntReg == (({4'h0, lenReg} + 12'h002) << sra_pkg::SPI_BITS_LOG2))
    else $error("frame clock count is not eight per byte");

  csLow_a: assert property (@(posedge clk) disable iff (rst)
    (!i2cReg && (isShift || stateReg == sra_pkg::ST_LOAD)) |-> !spiCsNReg)
    else $error("select high inside a frame");

endmodule // sra_host

// ---- sim/sra_dev_model.sv ----
// Behavioural model of the sensor register port seen from the host: two-wire slave and
// mode-00 serial slave over one 128-byte register file.
// Assumes the bench resolves the open-drain and three-state lines with pull-ups.
`timescale 1ns/1ns

module sra_dev_model #(
  parameter logic [6:0] CTRL_IDX = 7'h0d, // Index of control_register_zero; value is arbitrary.
  parameter int         WIRE_BIT = 0      // Bit of three_wire_select; value is arbitrary.
) (
  input  wire logic rst,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sdaLow,
  input  wire logic addressLsbPin,
  input  wire logic spiClk,
  input  wire logic spiCsN,
  input  wire logic spiData,
  output logic      sharedOe,
  output logic      misoOe,
  output logic      dataOut
);
  logic [7:0] mem [128];
  logic [7:0] sh, ob, ss, so;
  logic [6:0] ptr, sp;
  logic       srd = 1'b0, outOn = 1'b0;
  int         bn = 0, ph = 3, nx = 3, sc = 0;

  // ---------------------------------------------------------------------------
  // Reset and wire mode
  // ---------------------------------------------------------------------------
  // Power-on and reset clear every register, so the port wakes in four-wire mode.
  // The level is awaited, so a reset that is already high at time zero clears too.
  initial sdaLow = 1'b0;
  always begin
    wait (rst === 1'b1);
    foreach (mem[i]) mem[i] = 8'h00;
    ph = 3;
    sdaLow = 1'b0;
    wait (rst !== 1'b1);
  end
  assign sharedOe = outOn & mem[CTRL_IDX][WIRE_BIT];
  assign misoOe = outOn & ~mem[CTRL_IDX][WIRE_BIT];

  // ---------------------------------------------------------------------------
  // Two-wire slave
  // ---------------------------------------------------------------------------
  // Start and stop are data edges while the clock is high; the clock is never held.
  always @(negedge sda) if (scl === 1'b1) begin
    bn = 0;
    ph = 0;
    sdaLow = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    ph = 3;
    sdaLow = 1'b0;
  end
  // Bits are taken on the rising clock; a released line in a read slot ends the read.
  always @(posedge scl) if (ph != 3) begin
    if (bn < 8) sh = {sh[6:0], sda};
    else if (ph == 4 && sda) ph = 3;
    bn++;
  end
  // Outputs change on the falling clock: acknowledge in slot nine, read bits otherwise.
  always @(negedge scl) if (ph != 3) begin
    if (bn == 9) begin
      bn = 0;
      ph = nx;
      sdaLow = 1'b0;
      if (ph == 4) begin
        ob = mem[ptr];
        ptr++;
      end
    end
    if (bn == 8) begin
      sdaLow = ph != 4 && (ph != 0 || sh[7:1] == {6'h10, addressLsbPin});
      if (ph == 0) nx = !sdaLow ? 3 : sh[0] ? 4 : 1;
      else if (ph == 1) begin
        ptr = sh[6:0];
        nx = 2;
      end else if (ph == 2) begin
        mem[ptr] = sh;
        ptr++;
      end else nx = 4;
    end else if (ph == 4) sdaLow = !ob[3'(7 - bn)];
  end

  // ---------------------------------------------------------------------------
  // Serial slave, mode 00
  // ---------------------------------------------------------------------------
  // The model only answers a selected transfer and never starts one itself.
  always @(negedge spiCsN) begin
    sc = 0;
    srd = 1'b0;
    outOn = 1'b0;
  end
  always @(posedge spiCsN) outOn = 1'b0;
  always @(posedge spiClk) if (!spiCsN) begin
    ss = {ss[6:0], spiData};
    sc++;
    if (sc == 8) begin
      srd = ss[7];
      sp = ss[6:0];
    end else if (sc % 8 == 0 && !srd) begin
      mem[sp] = ss;
      sp++;
    end
  end
  always @(negedge spiClk) if (!spiCsN && srd && sc >= 8) begin
    if (sc % 8 == 0) begin
      so = mem[sp];
      sp++;
    end
    outOn = 1'b1;
    dataOut = so[3'(7 - sc % 8)];
  end
endmodule // sra_dev_model

// ---- sim/sra_host_tb.sv ----
// Self-checking bench for the serial register access host against the device model.
// Assumes the host body keeps the hand-over contract; pins resolve with pull-ups here.
`timescale 1ns/1ns

module sra_host_tb;
  localparam logic [6:0] CTRL_IDX = 7'h0d;
  logic clk = 1'b0, rst = 1'b1, cmdValid = 1'b0, wrValid = 1'b0;
  logic addressLsbPin = 1'b0, threeWireSelect = 1'b0, devStrap = 1'b0;
  logic [7:0] wrData = 8'h00;
  sra_pkg::sra_cmd_s cmd = '0;
  wire logic cmdReady, wrReady, rdValid, done, nackSeen, sclOe, sdaOe, spiClk, spiCsN;
  wire logic spiDataOut, spiDataOe, devSdaLow, devSharedOe, devMisoOe, devOut, busy;
  wire logic sclOut, sdaOut;
  wire logic [7:0] rdData;
  wire logic scl = sclOe ? sclOut : 1'b1;
  wire logic sda = (sdaOe ? sdaOut : 1'b1) & ~devSdaLow;
  wire logic spiData = spiDataOe ? spiDataOut : (devSharedOe ? devOut : 1'b1);
  wire logic spiMiso = devMisoOe ? devOut : 1'b1;
  int error_cnt = 0, num_checks = 0, spiEdges = 0;
  logic [7:0] got [8];
  logic [7:0] wb [8];

  always #5 clk = ~clk;
  always @(posedge spiClk) spiEdges++;

  sra_host u_sra_host (.clk(clk), .rst(rst), .ce(1'b1), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmd(cmd), .addressLsbPin(addressLsbPin),
    .threeWireSelect(threeWireSelect), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData), .rdValid(rdValid), .rdData(rdData), .done(done), .nackSeen(nackSeen),
    .busy(busy), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .spiClk(spiClk), .spiCsN(spiCsN), .spiDataIn(spiData), .spiDataOut(spiDataOut),
    .spiDataOe(spiDataOe), .spiMiso(spiMiso));
  sra_dev_model #(.CTRL_IDX(CTRL_IDX), .WIRE_BIT(0)) u_sra_dev_model (.rst(rst), .scl(scl),
    .sda(sda), .sdaLow(devSdaLow), .addressLsbPin(devStrap), .spiClk(spiClk),
    .spiCsN(spiCsN), .spiData(spiData), .sharedOe(devSharedOe), .misoOe(devMisoOe),
    .dataOut(devOut));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Compares one value and counts it; a mismatch is reported at once.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Issues one command, feeds write bytes from wb and gathers read bytes into got.
  task automatic run(input logic i2c, input logic rd, input logic [6:0] idx, input int n);
    int k;
    int t;
    k = 0;
    spiEdges = 0;
    cmdValid <= 1'b1;
    cmd <= '{useI2c: i2c, isRead: rd, regIndex: idx, extraBytes: 8'(n - 1)};
    wrValid <= !rd;
    wrData <= wb[0];
    @(posedge clk);
    check("cmdReady", {7'h00, cmdReady}, 8'h01);
    cmdValid <= 1'b0;
    for (t = 0; t < 60000; t++) begin
      @(posedge clk);
      if (t == 0) check("busy", {7'h00, busy}, 8'h01);
      if (!rd && wrValid && wrReady) begin
        k++;
        wrData <= wb[k[2:0]];
        if (k == n) wrValid <= 1'b0;
      end
      if (rd && rdValid) begin
        got[k[2:0]] = rdData;
        k++;
      end
      if (done) break;
    end
    if (t == 60000) begin
      error_cnt++;
      $display("ERROR done expected 1 seen 0");
      finish_test();
    end
    check("busyEnd", {7'h00, busy}, 8'h00);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Four-wire burst write then burst read of three consecutive registers.
  task automatic spi_burst();
    wb[0] = 8'ha5;
    wb[1] = 8'h3c;
    wb[2] = 8'h81;
    run(1'b0, 1'b0, 7'h05, 3);
    check("writeClocks", 8'(spiEdges), 8'h20);
    check("linkIdle", {6'h00, spiCsN, spiClk}, 8'h02);
    for (int i = 0; i < 3; i++) check("regWritten", u_sra_dev_model.mem[5 + i], wb[i]);
    run(1'b0, 1'b1, 7'h05, 3);
    check("readClocks", 8'(spiEdges), 8'h20);
    for (int i = 0; i < 3; i++) check("readByte", got[i], wb[i]);
  endtask

  // Switches the device to three-wire mode and reads back over the shared line.
  task automatic three_wire();
    check("ctrlReset", u_sra_dev_model.mem[CTRL_IDX], 8'h00);
    wb[0] = 8'h01;
    run(1'b0, 1'b0, CTRL_IDX, 1);
    threeWireSelect <= 1'b1;
    run(1'b0, 1'b1, 7'h06, 2);
    check("shared0", got[0], 8'h3c);
    check("shared1", got[1], 8'h81);
    check("sharedFree", {7'h00, devSharedOe}, 8'h00);
  endtask

  // Two-wire burst write then burst read with the strap high.
  task automatic i2c_burst();
    devStrap <= 1'b1;
    addressLsbPin <= 1'b1;
    wb[0] = 8'h5a;
    wb[1] = 8'hc3;
    run(1'b1, 1'b0, 7'h10, 2);
    check("wrAck", {7'h00, nackSeen}, 8'h00);
    check("reg10", u_sra_dev_model.mem[16], 8'h5a);
    check("reg11", u_sra_dev_model.mem[17], 8'hc3);
    run(1'b1, 1'b1, 7'h10, 2);
    check("rdAck", {7'h00, nackSeen}, 8'h00);
    check("i2cRd0", got[0], 8'h5a);
    check("i2cRd1", got[1], 8'hc3);
  endtask

  // Wrong address: no acknowledge, stop, and the bus returns to idle.
  task automatic i2c_nack();
    addressLsbPin <= 1'b0;
    run(1'b1, 1'b1, 7'h10, 1);
    check("nackSeen", {7'h00, nackSeen}, 8'h01);
    check("busFree", {6'h00, scl, sda}, 8'h03);
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    spi_burst();
    three_wire();
    i2c_burst();
    i2c_nack();
    finish_test();
  end
endmodule // sra_host_tb
